// ---- src/chan_pipe_pkg.sv ----
// Shared constants of the channel-to-pipeline dispatch block.
// Assumes one clock domain; all users import the whole package.
package chan_pipe_pkg;
   // ----------------------------------------
   // Build defaults and limits
   // ----------------------------------------
   localparam int CHAN_RADIX_DEF = 8;
   localparam int CHAN_RADIX_MAX = 8;
   localparam int PIPE_RADIX_DEF = 4;
   localparam int PIPE_RADIX_MAX = 4;
   localparam int BURST_RADIX_DEF = 2;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int MEM_WIDTH = 64;
   localparam int WORD_BYTES_LOG2 = 3;
   localparam int DIMS = 4;
   localparam int DIM_W = 16;
   localparam int IDX_W = 65;
   localparam int GATE_EXTRA = 13;
   localparam int DECIDE_CYCLES = 2;
   // ----------------------------------------
   // Host map and fields
   // ----------------------------------------
   localparam logic [31:0] OFS_BASE = 32'h0000_0000;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
   localparam logic [31:0] OFS_ACTIVATE = 32'h0000_0008;
   localparam logic [31:0] BASE_RST = 32'h0000_0000;
   localparam int ACT_OPT_BIT = 30;
   localparam int ACT_OFF_BIT = 31;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_FETCH_BIT = 1;
   // Parameter word 0: {addr, delta, pipe}; word 1: widths {W,Z,Y,X}
   localparam int P_ADDR_POS = 32;
   localparam int P_DELTA_POS = 16;
   localparam int P_PIPE_POS = 0;
endpackage

// ---- src/channel_pipe_dispatch_ports.sv ----
// Scheduler core: channel scan, parameter fetch, pipeline dispatch and completion.
// Assumes pipelines, host and memory run on the same clock.
// How it works
// - Up to 256 logical channels share up to 16 pipelines, both parameterised.
// - Channel count is two to the channel radix, default 8, at most 8.
// - Pipeline count is two to the pipeline radix, default 4, at most 4.
// - Burst radix sets the fetch burst in 64-bit words.
// - Memory port is a single 64-bit read-only path for channel parameters.
// - Missing channel parameters are fetched from memory automatically.
// - At most one pipeline launch every two cycles.
// - Channels are examined one at a time by a scanning pointer.
// - Host direction and address are taken only when request and grant are high.
// - Restore output marks a frame invalid, reuse previous result.
// - Four end bits flag the last fragment of each index dimension.
// - Each dispatch carries a 32-bit context address.
// - Each dispatch carries a 16-bit fragment length.
// - Start index is packed as cycle bit then W, Z, Y, X.
// - Early dispatch request rises one clock before dispatch valid.
// - Early completion request is up before completion is expected.
// - Activation stall is high while a channel is busy.
// - Gate controls report activity of each internal block.
// - One scheduling decision takes two cycles.
module channel_pipe_dispatch_ports
   import chan_pipe_pkg::*;
#(
   parameter int CHANNEL_COUNT_RADIX = CHAN_RADIX_DEF,
   parameter int PIPE_COUNT_RADIX = PIPE_RADIX_DEF,
   parameter int BURST_LENGTH_RADIX = BURST_RADIX_DEF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Host control bus
   input wire logic hostCmdRequest,
   output logic hostCmdGrant,
   input wire logic hostCmdRw,
   input wire logic [31:0] hostCmdAddr,
   output logic hostWriteAccept,
   input wire logic [31:0] hostWriteData,
   output logic hostReadReturn,
   output logic [31:0] hostReadData,
   output logic hostIrq,
   // Parameter fetch port
   output logic paramFetchRequest,
   input wire logic paramFetchGrant,
   output logic [31:0] paramFetchAddr,
   input wire logic paramFetchStrobe,
   input wire logic paramFetchAck,
   input wire logic paramFetchFlush,
   input wire logic [MEM_WIDTH-1:0] paramFetchData,
   // Pipeline dispatch
   output logic [(1<<PIPE_COUNT_RADIX)-1:0] dispatchValid,
   input wire logic [(1<<PIPE_COUNT_RADIX)-1:0] dispatchStall,
   input wire logic [(1<<PIPE_COUNT_RADIX)-1:0] dispatchBufferReady,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0] dispatchRestore,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0][CHANNEL_COUNT_RADIX-1:0] dispatchId,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0][DIMS-1:0] dispatchEnd,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0][31:0] dispatchAddr,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0][DIM_W-1:0] dispatchDelta,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0][IDX_W-1:0] dispatchIndex,
   // Pipeline completion
   input wire logic [(1<<PIPE_COUNT_RADIX)-1:0] completionValid,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0] completionStall,
   // Channel activation
   input wire logic [(1<<CHANNEL_COUNT_RADIX)-1:0] chanActivateValid,
   output logic [(1<<CHANNEL_COUNT_RADIX)-1:0] chanActivateStall,
   input wire logic [(1<<CHANNEL_COUNT_RADIX)-1:0] chanActivateOption,
   input wire logic [(1<<CHANNEL_COUNT_RADIX)-1:0] chanDeactivateLine,
   // Clock gating
   output logic [(1<<PIPE_COUNT_RADIX)-1:0] dispatchEarlyReq,
   output logic [(1<<PIPE_COUNT_RADIX)-1:0] completionEarlyReq,
   output logic [(1<<PIPE_COUNT_RADIX)+GATE_EXTRA-1:0] gateCtl
);
   localparam int NC = 1 << CHANNEL_COUNT_RADIX;
   localparam int NP = 1 << PIPE_COUNT_RADIX;
   localparam int CW = CHANNEL_COUNT_RADIX;
   localparam int PW = PIPE_COUNT_RADIX;

   if (CW < 1 || CW > CHAN_RADIX_MAX || PW < 1 || PW > PIPE_RADIX_MAX || BURST_LENGTH_RADIX < 1) begin : g_bad
      $error("channel_pipe_dispatch_ports: radix parameter out of range");
   end

   // ----------------------------------------
   // Index arithmetic
   // ----------------------------------------
   // Only X steps by the fragment length plus one; upper dimensions step by one.
   function automatic logic [DIMS-1:0] lastOf(logic [IDX_W-1:0] idx, logic [63:0] wid, logic [DIM_W-1:0] dl);
      logic [DIM_W:0] nxt;
      for (int d = 0; d < DIMS; d++) begin
         nxt = {1'b0, idx[d*DIM_W+:DIM_W]} + {1'b0, (d == 0) ? dl : 16'h0000} + 17'h0_0001;
         lastOf[d] = nxt > {1'b0, wid[d*DIM_W+:DIM_W]};
      end
   endfunction

   function automatic logic [IDX_W-1:0] advance(logic [IDX_W-1:0] idx, logic [63:0] wid, logic [DIM_W-1:0] dl);
      logic [DIMS-1:0] e;
      logic carry;
      e = lastOf(idx, wid, dl);
      carry = 1'b1;
      advance = idx;
      for (int d = 0; d < DIMS; d++) begin
         if (carry && e[d]) begin
            advance[d*DIM_W+:DIM_W] = 16'h0000;
         end else if (carry) begin
            advance[d*DIM_W+:DIM_W] = idx[d*DIM_W+:DIM_W] + ((d == 0) ? dl : 16'h0000) + 16'h0001;
            carry = 1'b0;
         end
      end
      if (carry) begin
         advance[IDX_W-1] = ~idx[IDX_W-1];
      end
   endfunction

   typedef enum logic [1:0] {F_IDLE, F_REQ, F_DATA} fetch_e;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [NC-1:0] active_r, loaded_r, inFlight_r, restorePend_r;
   logic [PW-1:0] chPipe_r [NC];
   logic [31:0] chAddr_r [NC];
   logic [DIM_W-1:0] chDelta_r [NC];
   logic [63:0] chWidth_r [NC];
   logic [IDX_W-1:0] chIdx_r [NC];
   logic phase_r, launchPend_r, hostPend_r, hostRw_r, doneSticky_r;
   logic [CW-1:0] scanCh_r, launchCh_r, fetchCh_r;
   logic [PW-1:0] launchPipe_r, token_r;
   logic [NP-1:0] awaitDone_r;
   logic [CW-1:0] doneCh_r [NP];
   logic [31:0] hostAddr_r, paramBase_r;
   logic [BURST_LENGTH_RADIX:0] wordCnt_r;
   fetch_e fetchSt_r;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire [PW-1:0] scanPipe = chPipe_r[scanCh_r];
   wire scanLive = active_r[scanCh_r] & ~inFlight_r[scanCh_r];
   wire pipeFree = dispatchBufferReady[scanPipe] & ~dispatchValid[scanPipe] & ~awaitDone_r[scanPipe];
   wire launch = ~phase_r & ~launchPend_r & scanLive & loaded_r[scanCh_r] & pipeFree;
   wire fetchStart = ~phase_r & scanLive & ~loaded_r[scanCh_r] & (fetchSt_r == F_IDLE);
   wire [CW-1:0] compCh = doneCh_r[token_r];
   wire compAcc = completionValid[token_r] & ~completionStall[token_r] & awaitDone_r[token_r];
   wire [IDX_W-1:0] compIdx = chIdx_r[compCh];
   wire frameDone = compAcc & (&lastOf(compIdx, chWidth_r[compCh], chDelta_r[compCh]));
   wire hostTake = hostCmdRequest & hostCmdGrant;
   wire wrBase = hostWriteAccept & (hostAddr_r == OFS_BASE);
   wire wrStatus = hostWriteAccept & (hostAddr_r == OFS_STATUS);
   wire irqClear = wrStatus & hostWriteData[ST_DONE_BIT];
   wire wrAct = hostWriteAccept & (hostAddr_r == OFS_ACTIVATE);
   wire [NC-1:0] hostChVec = NC'(1) << hostWriteData[CW-1:0];
   wire [NC-1:0] hostOn = (wrAct & ~hostWriteData[ACT_OFF_BIT]) ? hostChVec : '0;
   wire [NC-1:0] hostOff = (wrAct & hostWriteData[ACT_OFF_BIT]) ? hostChVec : '0;
   wire [NC-1:0] actAcc = (chanActivateValid | hostOn) & ~chanActivateStall;
   wire [NC-1:0] actOpt = chanActivateOption | (hostOn & {NC{hostWriteData[ACT_OPT_BIT]}});
   wire [NC-1:0] compVec = compAcc ? (NC'(1) << compCh) : '0;
   wire [NC-1:0] launchVec = launch ? (NC'(1) << scanCh_r) : '0;
   wire [NC-1:0] issueVec = launchPend_r ? (NC'(1) << launchCh_r) : '0;
   wire [NC-1:0] activeNxt = (active_r | actAcc) & ~(chanDeactivateLine | hostOff) & ~(frameDone ? compVec : '0);
   wire [NC-1:0] inFlightNxt = (inFlight_r | launchVec) & ~compVec;
   wire [31:0] statusWord = {30'h0000_0000, fetchSt_r != F_IDLE, doneSticky_r};

   // ----------------------------------------
   // Channel scan and channel flags
   // ----------------------------------------
   // A single pointer walks the channels, two cycles per decision.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_r <= 1'b0;
         scanCh_r <= '0;
         active_r <= '0;
         inFlight_r <= '0;
         restorePend_r <= '0;
         chanActivateStall <= '0;
      end else begin
         phase_r <= ~phase_r;
         if (phase_r) begin
            scanCh_r <= scanCh_r + 1'b1;
         end
         active_r <= activeNxt;
         inFlight_r <= inFlightNxt;
         // Kept until the first dispatch issues, so that dispatch still carries it
         restorePend_r <= (restorePend_r | (actAcc & actOpt)) & ~issueVec;
         chanActivateStall <= activeNxt | inFlightNxt;
      end
   end

   // Index memory; the cycle bit survives a fresh activation.
   always_ff @(posedge clock) begin
      for (int c = 0; c < NC; c++) begin
         if (actAcc[c] && !actOpt[c]) begin
            chIdx_r[c][IDX_W-2:0] <= '0;
         end
      end
      if (compAcc) begin
         chIdx_r[compCh] <= advance(compIdx, chWidth_r[compCh], chDelta_r[compCh]);
      end
   end

   // ----------------------------------------
   // Parameter fetch
   // ----------------------------------------
   // Only the first two words of a burst carry parameters; the rest is dropped.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fetchSt_r <= F_IDLE;
         fetchCh_r <= '0;
         wordCnt_r <= '0;
         loaded_r <= '0;
         paramFetchRequest <= 1'b0;
         paramFetchAddr <= '0;
      end else begin
         unique case (fetchSt_r)
            F_IDLE: if (fetchStart) begin
               fetchSt_r <= F_REQ;
               fetchCh_r <= scanCh_r;
               paramFetchRequest <= 1'b1;
               paramFetchAddr <= paramBase_r + (32'(scanCh_r) << (BURST_LENGTH_RADIX + WORD_BYTES_LOG2));
            end
            F_REQ: if (paramFetchGrant) begin
               fetchSt_r <= F_DATA;
               paramFetchRequest <= 1'b0;
               wordCnt_r <= '0;
            end
            F_DATA: begin
               if (paramFetchStrobe && wordCnt_r < 2) begin
                  wordCnt_r <= wordCnt_r + 1'b1;
               end
               if (paramFetchFlush) begin
                  fetchSt_r <= F_IDLE;
               end else if (paramFetchAck) begin
                  fetchSt_r <= F_IDLE;
                  loaded_r[fetchCh_r] <= wordCnt_r >= 2;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (fetchSt_r == F_DATA && paramFetchStrobe && wordCnt_r == 0) begin
         chAddr_r[fetchCh_r] <= paramFetchData[P_ADDR_POS+:32];
         chDelta_r[fetchCh_r] <= paramFetchData[P_DELTA_POS+:DIM_W];
         chPipe_r[fetchCh_r] <= paramFetchData[P_PIPE_POS+:PW];
      end
      if (fetchSt_r == F_DATA && paramFetchStrobe && wordCnt_r == 1) begin
         chWidth_r[fetchCh_r] <= paramFetchData;
      end
   end

   // ----------------------------------------
   // Dispatch and completion
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         launchPend_r <= 1'b0;
         launchCh_r <= '0;
         launchPipe_r <= '0;
         token_r <= '0;
         awaitDone_r <= '0;
         completionStall <= '1;
         dispatchValid <= '0;
         dispatchRestore <= '0;
         dispatchId <= '0;
         dispatchEnd <= '0;
         dispatchAddr <= '0;
         dispatchDelta <= '0;
         dispatchIndex <= '0;
         dispatchEarlyReq <= '0;
         completionEarlyReq <= '0;
         for (int p = 0; p < NP; p++) begin
            doneCh_r[p] <= '0;
         end
      end else begin
         launchPend_r <= launch;
         if (launch) begin
            launchCh_r <= scanCh_r;
            launchPipe_r <= scanPipe;
         end
         // Rotating token: one completion per cycle, stall is ready a cycle ahead.
         token_r <= token_r + 1'b1;
         completionStall <= ~(NP'(1) << PW'(token_r + 1'b1));
         for (int p = 0; p < NP; p++) begin
            dispatchEarlyReq[p] <= launch && scanPipe == PW'(p);
            if (launchPend_r && launchPipe_r == PW'(p)) begin
               dispatchValid[p] <= 1'b1;
               dispatchRestore[p] <= restorePend_r[launchCh_r];
               dispatchId[p] <= launchCh_r;
               dispatchEnd[p] <= lastOf(chIdx_r[launchCh_r], chWidth_r[launchCh_r], chDelta_r[launchCh_r]);
               dispatchAddr[p] <= chAddr_r[launchCh_r];
               dispatchDelta[p] <= chDelta_r[launchCh_r];
               dispatchIndex[p] <= chIdx_r[launchCh_r];
            end else if (dispatchValid[p] && !dispatchStall[p]) begin
               dispatchValid[p] <= 1'b0;
               awaitDone_r[p] <= 1'b1;
               completionEarlyReq[p] <= 1'b1;
               doneCh_r[p] <= dispatchId[p];
            end
            if (compAcc && token_r == PW'(p)) begin
               awaitDone_r[p] <= 1'b0;
               completionEarlyReq[p] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Host port, interrupt and gating
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hostCmdGrant <= 1'b0;
         hostPend_r <= 1'b0;
         hostRw_r <= 1'b0;
         hostAddr_r <= '0;
         hostWriteAccept <= 1'b0;
         hostReadReturn <= 1'b0;
         hostReadData <= '0;
         paramBase_r <= BASE_RST;
         doneSticky_r <= 1'b0;
         hostIrq <= 1'b0;
         gateCtl <= '0;
      end else begin
         hostCmdGrant <= hostCmdRequest & ~hostCmdGrant & ~hostPend_r & ~hostWriteAccept & ~hostReadReturn;
         hostPend_r <= hostTake;
         if (hostTake) begin
            hostRw_r <= hostCmdRw;
            hostAddr_r <= hostCmdAddr;
         end
         hostWriteAccept <= hostPend_r & ~hostRw_r;
         hostReadReturn <= hostPend_r & hostRw_r;
         if (hostPend_r && hostRw_r) begin
            hostReadData <= (hostAddr_r == OFS_BASE) ? paramBase_r : (hostAddr_r == OFS_STATUS) ? statusWord : '0;
         end
         if (wrBase) begin
            paramBase_r <= hostWriteData;
         end
         // A frame end in the clearing cycle keeps the flag set.
         doneSticky_r <= frameDone | (doneSticky_r & ~irqClear);
         hostIrq <= doneSticky_r;
         gateCtl <= {{(GATE_EXTRA-2){|active_r}}, fetchSt_r != F_IDLE, hostPend_r | hostCmdRequest,
                     dispatchValid | awaitDone_r | dispatchEarlyReq};
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_host_take;
      hostCmdRequest && hostCmdGrant |-> ##2 (hostWriteAccept != hostReadReturn);
   endproperty
   a_host_take: assert property (p_host_take) else $error("host command not answered");
   property p_early_disp;
      dispatchEarlyReq[0] |=> dispatchValid[0];
   endproperty
   a_early_disp: assert property (p_early_disp) else $error("dispatch valid missing after early request");
   property p_valid_led;
      $rose(dispatchValid[0]) |-> $past(dispatchEarlyReq[0]);
   endproperty
   a_valid_led: assert property (p_valid_led) else $error("dispatch valid without early request");
   property p_rate;
      (dispatchEarlyReq != '0) |-> $onehot(dispatchEarlyReq) ##1 (dispatchEarlyReq == '0);
   endproperty
   a_rate: assert property (p_rate) else $error("launches closer than two cycles");
   property p_hold;
      dispatchValid[0] && dispatchStall[0] |=> dispatchValid[0] && $stable(dispatchIndex[0]) && $stable(dispatchAddr[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("dispatch changed while stalled");
   property p_comp_early;
      completionValid[0] && !completionStall[0] && awaitDone_r[0] |-> completionEarlyReq[0];
   endproperty
   a_comp_early: assert property (p_comp_early) else $error("completion early request not raised");
   property p_irq_level;
      hostIrq && !irqClear && !$past(irqClear) |=> ##1 hostIrq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt dropped without clear");
   property p_act_stall;
      chanActivateValid[0] && !chanActivateStall[0] && !chanDeactivateLine[0] |=> chanActivateStall[0];
   endproperty
   a_act_stall: assert property (p_act_stall) else $error("accepted channel not busy");
   property p_scan;
      phase_r |=> scanCh_r == CW'($past(scanCh_r) + 1'b1) ##1 $stable(scanCh_r);
   endproperty
   a_scan: assert property (p_scan) else $error("scan pointer not stepping every two cycles");
   property p_fetch_req;
      paramFetchRequest && !paramFetchGrant |=> paramFetchRequest && $stable(paramFetchAddr);
   endproperty
   a_fetch_req: assert property (p_fetch_req) else $error("fetch request withdrawn");

   c_dispatch: cover property (dispatchValid[0] && !dispatchStall[0]);
   c_complete: cover property (compAcc && frameDone);
   c_fetch: cover property (fetchSt_r == F_DATA && paramFetchAck);
   c_irq: cover property ($rose(hostIrq));
endmodule // channel_pipe_dispatch_ports

// ---- tb/pipe_model.sv ----
// Partner model of the processing pipelines: takes dispatches, answers each with one completion.
// Assumes the block's clock and active-high reset; stalls and latencies come from a fixed seed.
module pipe_model #(
   parameter int NP = 2
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Dispatch side
   input wire logic [NP-1:0] dispatchValid,
   output logic [NP-1:0] dispatchStall,
   output logic [NP-1:0] dispatchBufferReady,
   // Completion side
   input wire logic [NP-1:0] completionStall,
   output logic [NP-1:0] completionValid
);
   timeunit 1ns;
   timeprecision 1ps;
   int seed = 76440;
   int waitT [NP];
   logic [NP-1:0] busy = '0;
   // Buffer of depth one: no room while a fragment is being worked on
   assign dispatchBufferReady = ~busy;
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         busy <= '0;
         dispatchStall <= '0;
         completionValid <= '0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            dispatchStall[p] <= #1 ($random(seed) % 3 == 0);
            if (dispatchValid[p] && !dispatchStall[p] && !busy[p]) begin
               busy[p] <= #1 1'b1;
               waitT[p] <= #1 2 + ($random(seed) & 7);
            end else if (busy[p] && !completionValid[p]) begin
               waitT[p] <= #1 waitT[p] - 1;
               // One completion per dispatch, once the work is written out
               if (waitT[p] == 0) completionValid[p] <= #1 1'b1;
            end else if (completionValid[p] && !completionStall[p]) begin
               completionValid[p] <= #1 1'b0;
               busy[p] <= #1 1'b0;
            end
         end
      end
   end
endmodule // pipe_model

// ---- tb/tb.sv ----
// Bench of the dispatch block: host bus, parameter fetch and one two-fragment frame.
// Assumes the design package is compiled first and pipe_model stands on the far side.
module tb
   import chan_pipe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CR = 2;
   localparam int PR = 1;
   localparam int NP = 1 << PR;
   localparam int NC = 1 << CR;
   logic clock = 0, rst = 1;
   logic hostCmdRequest = 0, hostCmdRw = 0, hostCmdGrant, hostWriteAccept, hostReadReturn, hostIrq;
   logic [31:0] hostCmdAddr = 0, hostWriteData = 0, hostReadData, paramFetchAddr, base, q, ctx;
   logic paramFetchRequest, paramFetchGrant = 0, paramFetchStrobe = 0, paramFetchAck = 0, paramFetchFlush = 0;
   logic [63:0] paramFetchData = 0;
   logic [NP-1:0] dispatchValid, dispatchStall, dispatchBufferReady, dispatchRestore, completionValid;
   logic [NP-1:0] completionStall, dispatchEarlyReq, completionEarlyReq, vPrev = 0, ePrev = 0;
   logic [NP-1:0][CR-1:0] dispatchId;
   logic [NP-1:0][3:0] dispatchEnd;
   logic [NP-1:0][31:0] dispatchAddr;
   logic [NP-1:0][15:0] dispatchDelta;
   logic [NP-1:0][64:0] dispatchIndex;
   logic [NC-1:0] chanActivateValid = 0, chanActivateStall, chanActivateOption = 0, chanDeactivateLine = 0;
   logic [NP+GATE_EXTRA-1:0] gateCtl;
   int seed = 76440, fails = 0, compares = 0, cyc = 0, n, ch, p;
   channel_pipe_dispatch_ports #(.CHANNEL_COUNT_RADIX(CR), .PIPE_COUNT_RADIX(PR)) i_dut (
      .clock, .rst, .hostCmdRequest, .hostCmdGrant, .hostCmdRw, .hostCmdAddr, .hostWriteAccept, .hostWriteData,
      .hostReadReturn, .hostReadData, .hostIrq, .paramFetchRequest, .paramFetchGrant, .paramFetchAddr,
      .paramFetchStrobe, .paramFetchAck, .paramFetchFlush, .paramFetchData, .dispatchValid, .dispatchStall,
      .dispatchBufferReady, .dispatchRestore, .dispatchId, .dispatchEnd, .dispatchAddr, .dispatchDelta,
      .dispatchIndex, .completionValid, .completionStall, .chanActivateValid, .chanActivateStall,
      .chanActivateOption, .chanDeactivateLine, .dispatchEarlyReq, .completionEarlyReq, .gateCtl);
   pipe_model #(.NP(NP)) i_pipes (.clock, .rst, .dispatchValid, .dispatchStall, .dispatchBufferReady,
      .completionStall, .completionValid);
   always #50 clock = ~clock;
   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Compares %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Address and direction are scrambled after the take edge: they must not be looked at again
   task automatic host(input logic rw, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clock) #1;
      {hostCmdRequest, hostCmdRw, hostCmdAddr, hostWriteData} = {1'b1, rw, a, d};
      n = 0;
      do @(posedge clock); while (hostCmdGrant !== 1'b1 && ++n < 20);
      #1 {hostCmdRequest, hostCmdRw, hostCmdAddr} = {1'b0, ~rw, ~a};
      n = 0;
      do @(posedge clock); while (hostWriteAccept !== 1'b1 && hostReadReturn !== 1'b1 && ++n < 20);
      r = hostReadData;
   endtask
   always @(posedge clock) begin
      cyc++;
      for (int i = 0; i < NP; i++)
         if (dispatchValid[i] === 1'b1 && vPrev[i] !== 1'b1)
            chk(ePrev[i], 1);
      vPrev = dispatchValid;
      ePrev = dispatchEarlyReq;
      if (cyc == 5000) begin
         fails++;
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clock);
      chk({completionStall, dispatchValid, hostIrq, hostCmdGrant}, 6'h30);
      #1 rst = 0;
      host(1, OFS_BASE, 0, q);
      chk(q, BASE_RST);
      base = $random(seed) & 32'hFFFF_F000;
      ch = $random(seed) & 3;
      p = $random(seed) & 1;
      ctx = $random(seed);
      host(0, OFS_BASE, base, q);
      host(0, 32'h0000_0010, 32'hFFFF_FFFF, q);
      host(1, OFS_BASE, 0, q);
      chk(q, base);
      host(1, 32'h0000_0010, 0, q);
      chk(q, 0);
      @(posedge clock) #1 chanActivateValid[ch] = 1;
      @(posedge clock) #1 chanActivateValid[ch] = 0;
      chk(chanActivateStall[ch], 1);
      // The first burst is flushed, so the channel has to be fetched a second time
      for (int f = 0; f < 2; f++) begin
         n = 0;
         do @(posedge clock); while (paramFetchRequest !== 1'b1 && ++n < 50);
         #1 paramFetchGrant = 1;
         chk(paramFetchAddr, base + ch * (1 << BURST_RADIX_DEF) * 8);
         @(posedge clock) #1 paramFetchGrant = 0;
         paramFetchFlush = (f == 0);
         @(posedge clock) #1 paramFetchFlush = 0;
      end
      @(posedge clock) #1 paramFetchData = {ctx, 16'h0001, 15'h0000, 1'(p)};
      paramFetchStrobe = 1;
      @(posedge clock) #1 paramFetchData = 64'h0000_0000_0000_0003;
      @(posedge clock) #1 {paramFetchStrobe, paramFetchAck} = 2'h1;
      paramFetchData = ~paramFetchData;
      @(posedge clock) #1 paramFetchAck = 0;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do @(posedge clock); while ((dispatchValid[p] !== 1'b1 || dispatchStall[p] !== 1'b0) && ++n < 300);
         chk(dispatchAddr[p], ctx);
         chk(dispatchDelta[p], 16'h0001);
         chk(dispatchIndex[p][63:0], 64'(2 * k));
         chk(dispatchEnd[p], k ? 4'hF : 4'hE);
         chk({dispatchRestore[p], dispatchId[p]}, {1'b0, 2'(ch)});
         chk({gateCtl[NP+GATE_EXTRA-1:NP+2], gateCtl[p]}, 12'hFFF);
         #1 chk(completionEarlyReq[p], 1);
         n = 0;
         do @(posedge clock); while ((completionValid[p] !== 1'b1 || completionStall[p] !== 1'b0) && ++n < 50);
         #1 chk(completionEarlyReq[p], 0);
      end
      n = 0;
      do @(posedge clock); while (hostIrq !== 1'b1 && ++n < 20);
      host(1, OFS_STATUS, 0, q);
      chk({hostIrq, q[ST_DONE_BIT], q[ST_FETCH_BIT], chanActivateStall[ch]}, 4'hC);
      host(0, OFS_STATUS, 32'h0000_0001, q);
      repeat (3) @(posedge clock);
      chk(hostIrq, 0);
      // Restart with the index kept, then switch the channel off while its fragment is out
      #1 {chanActivateValid[ch], chanActivateOption[ch]} = 2'h3;
      @(posedge clock) #1 {chanActivateValid[ch], chanActivateOption[ch]} = 2'h0;
      n = 0;
      do @(posedge clock); while ((dispatchValid[p] !== 1'b1 || dispatchStall[p] !== 1'b0) && ++n < 300);
      chk({dispatchRestore[p], dispatchIndex[p][62:0]}, {1'b1, 63'h0});
      #1 chanDeactivateLine[ch] = 1;
      n = 0;
      do @(posedge clock); while ((completionValid[p] !== 1'b1 || completionStall[p] !== 1'b0) && ++n < 50);
      #1 chanDeactivateLine[ch] = 0;
      chk(chanActivateStall[ch], 0);
      repeat (3) @(posedge clock);
      chk(gateCtl, 0);
      tally_and_finish();
   end
endmodule // tb
